/* src/lsd_ctrl.v */
// lo synthesizer digital control and per-block standby register
// assumes ref_in and lo_in are synchronous level inputs sampled on clock; a rising
// edge of either counts as one input cycle. register port is the decoded serial port.
`timescale 1ns/10ps
`include "lsd_regs.vh"

// Contract
// R1: standby register resets to all ones, every block starts in standby.
// R2: clearing a standby bit wakes that block; a one keeps it down.
// R3: bit 7 set turns off voltage reference and all biasing.
// R4: bit 6 set disables synthesizer and floats the pump output.
// R5: bit 2 set powers down amplifier and mixer and floats their pins.
// R6: bit 0 set stops converter, filter clock; clock buffer off if clock synth off.
// R7: all blocks in standby also puts master reference into standby.
// R8: reference input divided by 14-bit reference count feeds the detector.
// R9: feedback divider uses 3-bit swallow, 13-bit main count, 8/9 prescaler: 8B+A.
// R10: host keeps main count at least 3 and above swallow count.
// R11: pump current is (code + 1) times 0.625 mA.
// R12: fast acquire enable raises pump current automatically while settling.
// R13: detector gives up and down pulses tracking phase and frequency error.
// R14: pump sources or sinks only while the detector inputs disagree.
// R15: host uses one select line per device on a shared serial port.
// R16: prescaler divides by nine for A counts, eight for B minus A, then reloads.
module lsd_ctrl (
	input  wire       clock,
	input  wire       resetn,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata_ff,
	input  wire       ref_in,
	input  wire       lo_in,
	output reg        ref_off_ff,
	output reg        bias_off_ff,
	output reg        lo_synth_off_ff,
	output reg        front_end_off_ff,
	output reg        front_end_bias_pin_a_oe_n_ff,
	output reg        front_end_bias_pin_b_oe_n_ff,
	output reg        adc_off_ff,
	output reg        filter_clk_en_ff,
	output reg        clk_buffer_off_ff,
	output reg        master_ref_standby_ff,
	output reg        local_osc_pump_output_up_ff,
	output reg        local_osc_pump_output_down_ff,
	output reg        local_osc_pump_output_oe_n_ff,
	output reg  [3:0] pump_current_mult_ff,
	output reg        ref_div_pulse_ff,
	output reg        fb_div_pulse_ff
);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	reg [7:0]  standby_control_ff;
	reg [13:0] reference_divide_count_ff;
	reg [2:0]  swallow_count_ff;
	reg [12:0] main_count_ff;
	reg [6:0]  pump_ctrl_ff;
	reg [13:0] fa_period_ff;

	wire       fast_acquire_enable;
	wire       pump_invert;
	wire [2:0] pump_current_code;
	wire       lo_hold;

	assign fast_acquire_enable = pump_ctrl_ff[`LSD_PC_FAST];
	assign pump_invert         = pump_ctrl_ff[`LSD_PC_INV];
	assign pump_current_code   = pump_ctrl_ff[`LSD_PC_CODE_HI:`LSD_PC_CODE_LO];
	assign lo_hold             = standby_control_ff[`LSD_SB_LO];

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			standby_control_ff        <= `LSD_RST_STANDBY;  // [R1]
			reference_divide_count_ff <= {`LSD_RST_REF_HI, `LSD_RST_REF_LO};
			swallow_count_ff          <= `LSD_RST_SWALLOW;
			main_count_ff             <= {`LSD_RST_MAIN_HI, `LSD_RST_MAIN_LO};
			pump_ctrl_ff              <= `LSD_RST_PUMP_CTRL;
			fa_period_ff              <= {`LSD_RST_FA_HI, `LSD_RST_FA_LO};
		end else if (reg_wr) begin
			case (reg_addr)
			`LSD_ADDR_STANDBY: begin
				standby_control_ff <= reg_wdata;  // [R2]
			end
			`LSD_ADDR_REF_HI: begin
				reference_divide_count_ff[13:8] <= reg_wdata[5:0];
			end
			`LSD_ADDR_REF_LO: begin
				reference_divide_count_ff[7:0] <= reg_wdata;
			end
			`LSD_ADDR_SWALLOW_MAIN: begin
				swallow_count_ff    <= reg_wdata[7:5];
				main_count_ff[12:8] <= reg_wdata[4:0];
			end
			`LSD_ADDR_MAIN_LO: begin
				main_count_ff[7:0] <= reg_wdata;
			end
			`LSD_ADDR_PUMP_CTRL: begin
				pump_ctrl_ff <= reg_wdata[6:0];
			end
			`LSD_ADDR_FA_HI: begin
				fa_period_ff[13:8] <= reg_wdata[5:0];
			end
			`LSD_ADDR_FA_LO: begin
				fa_period_ff[7:0] <= reg_wdata;
			end
			default: begin
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// read-back
	// ---------------------------------------------------------------
	wire       pfd_up;
	wire       pfd_down;
	wire [2:0] width_steps;
	wire       pulse_end;
	reg  [7:0] nxt_rdata;

	always @* begin
		case (reg_addr)
		`LSD_ADDR_STANDBY:      nxt_rdata = standby_control_ff;
		`LSD_ADDR_REF_HI:       nxt_rdata = {2'b00, reference_divide_count_ff[13:8]};
		`LSD_ADDR_REF_LO:       nxt_rdata = reference_divide_count_ff[7:0];
		`LSD_ADDR_SWALLOW_MAIN: nxt_rdata = {swallow_count_ff, main_count_ff[12:8]};
		`LSD_ADDR_MAIN_LO:      nxt_rdata = main_count_ff[7:0];
		`LSD_ADDR_PUMP_CTRL:    nxt_rdata = {1'b0, pump_ctrl_ff};
		`LSD_ADDR_FA_HI:        nxt_rdata = {2'b00, fa_period_ff[13:8]};
		`LSD_ADDR_FA_LO:        nxt_rdata = fa_period_ff[7:0];
		`LSD_ADDR_STATUS:       nxt_rdata = {pump_current_mult_ff, width_steps[1:0], pfd_down, pfd_up};
		default:                nxt_rdata = 8'h00;
		endcase
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn)
			reg_rdata_ff <= 8'h00;
		else if (reg_rd)
			reg_rdata_ff <= nxt_rdata;
	end

	// ---------------------------------------------------------------
	// standby decode
	// ---------------------------------------------------------------
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ref_off_ff                   <= 1'b1;
			bias_off_ff                  <= 1'b1;
			lo_synth_off_ff              <= 1'b1;
			front_end_off_ff             <= 1'b1;
			front_end_bias_pin_a_oe_n_ff <= 1'b1;
			front_end_bias_pin_b_oe_n_ff <= 1'b1;
			adc_off_ff                   <= 1'b1;
			filter_clk_en_ff             <= 1'b0;
			clk_buffer_off_ff            <= 1'b1;
			master_ref_standby_ff        <= 1'b1;
		end else begin
			ref_off_ff                   <= standby_control_ff[`LSD_SB_REF];        // [R3]
			bias_off_ff                  <= standby_control_ff[`LSD_SB_REF];        // [R3]
			lo_synth_off_ff              <= standby_control_ff[`LSD_SB_LO];         // [R4]
			front_end_off_ff             <= standby_control_ff[`LSD_SB_FRONT_END];  // [R5]
			front_end_bias_pin_a_oe_n_ff <= standby_control_ff[`LSD_SB_FRONT_END];  // [R5]
			front_end_bias_pin_b_oe_n_ff <= standby_control_ff[`LSD_SB_FRONT_END];  // [R5]
			adc_off_ff                   <= standby_control_ff[`LSD_SB_ADC];        // [R6]
			filter_clk_en_ff             <= ~standby_control_ff[`LSD_SB_ADC];       // [R6]
			clk_buffer_off_ff            <= standby_control_ff[`LSD_SB_ADC]
			                              & standby_control_ff[`LSD_SB_CK];         // [R6]
			master_ref_standby_ff        <= ((standby_control_ff & `LSD_SB_USED_MASK)
			                              == `LSD_SB_USED_MASK);                    // [R7]
		end
	end

	// ---------------------------------------------------------------
	// input edge detect
	// ---------------------------------------------------------------
	reg  ref_in_d_ff;
	reg  lo_in_d_ff;
	wire ref_edge;
	wire lo_edge;

	assign ref_edge = ref_in & ~ref_in_d_ff;
	assign lo_edge  = lo_in & ~lo_in_d_ff;

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ref_in_d_ff <= 1'b0;
			lo_in_d_ff  <= 1'b0;
		end else begin
			ref_in_d_ff <= ref_in;
			lo_in_d_ff  <= lo_in;
		end
	end

	// ---------------------------------------------------------------
	// reference divider
	// ---------------------------------------------------------------
	reg  [13:0] ref_cnt_ff;
	wire [13:0] ref_div;

	// a zero count behaves as divide by one rather than stalling the detector
	assign ref_div = (reference_divide_count_ff == 14'h0000) ? 14'h0001 : reference_divide_count_ff;

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ref_cnt_ff       <= 14'h0000;
			ref_div_pulse_ff <= 1'b0;
		end else if (lo_hold) begin
			ref_cnt_ff       <= 14'h0000;
			ref_div_pulse_ff <= 1'b0;
		end else begin
			ref_div_pulse_ff <= 1'b0;
			if (ref_edge) begin
				if (ref_cnt_ff + 14'h0001 >= ref_div) begin
					ref_cnt_ff       <= 14'h0000;
					ref_div_pulse_ff <= 1'b1;  // [R8]
				end else begin
					ref_cnt_ff <= ref_cnt_ff + 14'h0001;  // [R8]
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// feedback divider: prescaler plus swallow and main counters
	// ---------------------------------------------------------------
	reg  [3:0]  pre_cnt_ff;
	reg  [2:0]  a_left_ff;
	reg  [12:0] b_cnt_ff;
	wire [3:0]  modulus;
	wire        pre_done;

	// divide by nine while swallow counts remain [R16]
	assign modulus  = (a_left_ff != 3'h0) ? `LSD_PRESCALE_HIGH : `LSD_PRESCALE_LOW;
	assign pre_done = lo_edge & (pre_cnt_ff + 4'h1 >= modulus);

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pre_cnt_ff      <= 4'h0;
			a_left_ff       <= 3'h0;
			b_cnt_ff        <= 13'h0000;
			fb_div_pulse_ff <= 1'b0;
		end else if (lo_hold) begin
			pre_cnt_ff      <= 4'h0;
			a_left_ff       <= swallow_count_ff;
			b_cnt_ff        <= 13'h0000;
			fb_div_pulse_ff <= 1'b0;
		end else begin
			fb_div_pulse_ff <= 1'b0;
			if (pre_done) begin
				pre_cnt_ff <= 4'h0;
				// relies on the host keeping main count above swallow count [R10]
				if (b_cnt_ff + 13'h0001 >= main_count_ff) begin
					b_cnt_ff        <= 13'h0000;
					a_left_ff       <= swallow_count_ff;  // [R16]
					fb_div_pulse_ff <= 1'b1;              // [R9]
				end else begin
					b_cnt_ff <= b_cnt_ff + 13'h0001;      // [R9]
					if (a_left_ff != 3'h0)
						a_left_ff <= a_left_ff - 3'h1;    // [R16]
				end
			end else if (lo_edge) begin
				pre_cnt_ff <= pre_cnt_ff + 4'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// detector and charge pump
	// ---------------------------------------------------------------
	lsd_pfd u_pfd (
		.clock          (clock),
		.resetn         (resetn),
		.hold           (lo_hold),
		.ref_pulse      (ref_div_pulse_ff),
		.fb_pulse       (fb_div_pulse_ff),
		.fa_period      (fa_period_ff),
		.up_ff          (pfd_up),
		.down_ff        (pfd_down),
		.width_steps_ff (width_steps),
		.pulse_end_ff   (pulse_end)
	);

	reg [2:0] fa_steps_ff;
	reg [2:0] nxt_boost;

	always @* begin
		nxt_boost = 3'h1;
		if (pump_current_code > nxt_boost)
			nxt_boost = pump_current_code;
		if (fa_steps_ff > nxt_boost)
			nxt_boost = fa_steps_ff;
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fa_steps_ff                   <= 3'h0;
			pump_current_mult_ff          <= 4'h1;
			local_osc_pump_output_up_ff   <= 1'b0;
			local_osc_pump_output_down_ff <= 1'b0;
			local_osc_pump_output_oe_n_ff <= 1'b1;
		end else begin
			if (pulse_end)
				fa_steps_ff <= width_steps;  // width of last pulse sets the next
			if (fast_acquire_enable)
				pump_current_mult_ff <= {1'b0, nxt_boost} + 4'h1;          // [R12]
			else
				pump_current_mult_ff <= {1'b0, pump_current_code} + 4'h1;  // [R11]
			local_osc_pump_output_oe_n_ff <= lo_hold;  // [R4]
			if (lo_hold) begin
				local_osc_pump_output_up_ff   <= 1'b0;
				local_osc_pump_output_down_ff <= 1'b0;
			end else begin
				local_osc_pump_output_up_ff   <= pump_invert ? pfd_down : pfd_up;  // [R14]
				local_osc_pump_output_down_ff <= pump_invert ? pfd_up : pfd_down;  // [R14]
			end
		end
	end

endmodule

/* src/lsd_regs.vh */
// register offsets, field positions and reset values of the lo synthesizer control block
// assumes registers are written through the device's serial register port, one byte per address
`ifndef LSD_REGS_VH
`define LSD_REGS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define LSD_ADDR_STANDBY      8'h00
`define LSD_ADDR_REF_HI       8'h08
`define LSD_ADDR_REF_LO       8'h09
`define LSD_ADDR_SWALLOW_MAIN 8'h0a
`define LSD_ADDR_MAIN_LO      8'h0b
`define LSD_ADDR_PUMP_CTRL    8'h0c
`define LSD_ADDR_FA_HI        8'h0d
`define LSD_ADDR_FA_LO        8'h0e
`define LSD_ADDR_STATUS       8'h10

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LSD_RST_STANDBY       8'hff
`define LSD_RST_REF_HI        6'h00
`define LSD_RST_REF_LO        8'h38
`define LSD_RST_SWALLOW       3'h5
`define LSD_RST_MAIN_HI       5'h00
`define LSD_RST_MAIN_LO       8'h1d
`define LSD_RST_PUMP_CTRL     7'h00
`define LSD_RST_FA_HI         6'h00
`define LSD_RST_FA_LO         8'h04

// ---------------------------------------------------------------
// standby bit positions
// ---------------------------------------------------------------
`define LSD_SB_REF            7
`define LSD_SB_LO             6
`define LSD_SB_CKO            5
`define LSD_SB_CK             4
`define LSD_SB_GC             3
`define LSD_SB_FRONT_END      2
`define LSD_SB_ADC            0
// every implemented standby bit; bit 1 is unused
`define LSD_SB_USED_MASK      8'hfd

// ---------------------------------------------------------------
// pump control fields
// ---------------------------------------------------------------
`define LSD_PC_FAST           6
`define LSD_PC_INV            5
`define LSD_PC_CODE_HI        4
`define LSD_PC_CODE_LO        2

// ---------------------------------------------------------------
// prescaler moduli and pump multiplier limits
// ---------------------------------------------------------------
`define LSD_PRESCALE_LOW      4'h8
`define LSD_PRESCALE_HIGH     4'h9
`define LSD_FA_STEP_MAX       3'h7

`endif

/* src/lsd_pfd.v */
// phase-frequency detector with pulse-width measurement for fast acquire
// assumes ref_pulse and fb_pulse are single-cycle events on the system clock
`timescale 1ns/10ps
`include "lsd_regs.vh"

module lsd_pfd (
	input  wire        clock,
	input  wire        resetn,
	input  wire        hold,
	input  wire        ref_pulse,
	input  wire        fb_pulse,
	input  wire [13:0] fa_period,
	output reg         up_ff,
	output reg         down_ff,
	output reg  [2:0]  width_steps_ff,
	output reg         pulse_end_ff
);

	reg [13:0] width_cnt_ff;
	reg [2:0]  step_run_ff;
	wire       active;
	wire       both;
	wire [13:0] period;

	assign active = up_ff | down_ff;
	assign both   = (up_ff | ref_pulse) & (down_ff | fb_pulse);
	assign period = (fa_period == 14'h0000) ? 14'h0001 : fa_period;

	// ---------------------------------------------------------------
	// detector flops
	// ---------------------------------------------------------------
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			up_ff   <= 1'b0;
			down_ff <= 1'b0;
		end else if (hold) begin
			up_ff   <= 1'b0;
			down_ff <= 1'b0;
		end else if (both) begin
			// both edges seen: clear together, width reflects the lead [R13]
			up_ff   <= 1'b0;
			down_ff <= 1'b0;
		end else begin
			up_ff   <= up_ff | ref_pulse;   // [R13]
			down_ff <= down_ff | fb_pulse;  // [R13]
		end
	end

	// ---------------------------------------------------------------
	// width measured in units of the fast-acquire period
	// ---------------------------------------------------------------
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			width_cnt_ff   <= 14'h0000;
			step_run_ff    <= 3'h0;
			width_steps_ff <= 3'h0;
			pulse_end_ff   <= 1'b0;
		end else if (hold) begin
			width_cnt_ff   <= 14'h0000;
			step_run_ff    <= 3'h0;
			width_steps_ff <= 3'h0;
			pulse_end_ff   <= 1'b0;
		end else begin
			pulse_end_ff <= 1'b0;
			if (active) begin
				if (width_cnt_ff + 14'h0001 >= period) begin
					width_cnt_ff <= 14'h0000;
					if (step_run_ff != `LSD_FA_STEP_MAX)
						step_run_ff <= step_run_ff + 3'h1;
				end else begin
					width_cnt_ff <= width_cnt_ff + 14'h0001;
				end
			end else if (width_cnt_ff != 14'h0000 || step_run_ff != 3'h0) begin
				// pulse just ended: publish its width for the next pulse
				width_steps_ff <= step_run_ff;
				pulse_end_ff   <= 1'b1;
				width_cnt_ff   <= 14'h0000;
				step_run_ff    <= 3'h0;
			end
		end
	end

endmodule

/* dv/lsd_src.sv */
// reference and lo source standing in for the external oscillators
// assumes half periods of at least one cycle so each input has a low cycle
`timescale 1ns/10ps

module lsd_src (
	input  wire       clock,
	input  wire       resetn,
	input  wire [3:0] ref_half,
	input  wire [3:0] lo_half,
	output reg        ref_in,
	output reg        lo_in
);
	reg [3:0] ref_cnt_ff;
	reg [3:0] lo_cnt_ff;

	// changes on the falling edge so the block samples settled levels
	always @(negedge clock or negedge resetn) begin
		if (!resetn) begin
			ref_cnt_ff <= 4'h0;
			lo_cnt_ff <= 4'h0;
			ref_in <= 1'b0;
			lo_in <= 1'b0;
		end else begin
			ref_cnt_ff <= (ref_cnt_ff >= ref_half - 4'h1) ? 4'h0 : ref_cnt_ff + 4'h1;
			lo_cnt_ff <= (lo_cnt_ff >= lo_half - 4'h1) ? 4'h0 : lo_cnt_ff + 4'h1;
			if (ref_cnt_ff >= ref_half - 4'h1)
				ref_in <= ~ref_in;
			if (lo_cnt_ff >= lo_half - 4'h1)
				lo_in <= ~lo_in;
		end
	end
endmodule

/* dv/lsd_chk.sv */
// port-level assertions for the lo synthesizer control block
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/10ps
`include "lsd_regs.vh"

module lsd_chk (
	input wire       clock,
	input wire       resetn,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       ref_off_ff,
	input wire       bias_off_ff,
	input wire       lo_synth_off_ff,
	input wire       front_end_off_ff,
	input wire       front_end_bias_pin_a_oe_n_ff,
	input wire       front_end_bias_pin_b_oe_n_ff,
	input wire       adc_off_ff,
	input wire       filter_clk_en_ff,
	input wire       clk_buffer_off_ff,
	input wire       master_ref_standby_ff,
	input wire       local_osc_pump_output_up_ff,
	input wire       local_osc_pump_output_down_ff,
	input wire       local_osc_pump_output_oe_n_ff,
	input wire [3:0] pump_current_mult_ff,
	input wire       ref_div_pulse_ff,
	input wire       fb_div_pulse_ff
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	property p_rst;
		$rose(resetn) |-> ref_off_ff && lo_synth_off_ff && adc_off_ff && master_ref_standby_ff;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not in standby after reset");
	property p_wake;
		reg_wr && reg_addr == `LSD_ADDR_STANDBY |-> ##2 {ref_off_ff, lo_synth_off_ff, front_end_off_ff,
			adc_off_ff} == {$past(reg_wdata[7], 2), $past(reg_wdata[6], 2), $past(reg_wdata[2], 2), $past(reg_wdata[0], 2)};
	endproperty
	a_wake: assert property (p_wake) else $error("standby write not decoded");
	property p_ref;
		ref_off_ff == bias_off_ff;
	endproperty
	a_ref: assert property (p_ref) else $error("bias and reference disagree");
	property p_lo;
		lo_synth_off_ff == local_osc_pump_output_oe_n_ff;
	endproperty
	a_lo: assert property (p_lo) else $error("pump float does not follow synth off");
	property p_lo_quiet;
		lo_synth_off_ff [*3] |-> !local_osc_pump_output_up_ff && !local_osc_pump_output_down_ff;
	endproperty
	a_lo_quiet: assert property (p_lo_quiet) else $error("pump active while synth off");
	property p_fe;
		front_end_off_ff == front_end_bias_pin_a_oe_n_ff && front_end_off_ff == front_end_bias_pin_b_oe_n_ff;
	endproperty
	a_fe: assert property (p_fe) else $error("front end pins not floated with front end");
	property p_adc;
		adc_off_ff != filter_clk_en_ff && (clk_buffer_off_ff -> adc_off_ff);
	endproperty
	a_adc: assert property (p_adc) else $error("converter standby decode wrong");
	property p_mref;
		master_ref_standby_ff |-> ref_off_ff && lo_synth_off_ff && front_end_off_ff && adc_off_ff;
	endproperty
	a_mref: assert property (p_mref) else $error("master reference down while a block runs");
	property p_rpul;
		ref_div_pulse_ff |=> !ref_div_pulse_ff;
	endproperty
	a_rpul: assert property (p_rpul) else $error("reference pulse longer than one cycle");
	property p_fpul;
		fb_div_pulse_ff |=> !fb_div_pulse_ff [*8];
	endproperty
	a_fpul: assert property (p_fpul) else $error("feedback pulses too close");
	property p_mult;
		pump_current_mult_ff >= 4'h1 && pump_current_mult_ff <= 4'h8;
	endproperty
	a_mult: assert property (p_mult) else $error("pump multiple out of range");
	property p_pfd;
		!(local_osc_pump_output_up_ff && local_osc_pump_output_down_ff);
	endproperty
	a_pfd: assert property (p_pfd) else $error("pump sources and sinks at once");

	c_wr: cover property (reg_wr && reg_addr == `LSD_ADDR_STANDBY);
	c_fb: cover property (fb_div_pulse_ff);
	c_up: cover property (local_osc_pump_output_up_ff);
endmodule

bind lsd_ctrl lsd_chk lsd_chk_inst (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .ref_off_ff, .bias_off_ff,
	.lo_synth_off_ff, .front_end_off_ff, .front_end_bias_pin_a_oe_n_ff, .front_end_bias_pin_b_oe_n_ff, .adc_off_ff,
	.filter_clk_en_ff, .clk_buffer_off_ff, .master_ref_standby_ff, .local_osc_pump_output_up_ff,
	.local_osc_pump_output_down_ff, .local_osc_pump_output_oe_n_ff, .pump_current_mult_ff, .ref_div_pulse_ff,
	.fb_div_pulse_ff);

/* dv/testbench.sv */
// self-checking bench for the lo synthesizer control block
// assumes the decoded byte register port and the source model on ref_in and lo_in
`timescale 1ns/10ps
`include "lsd_regs.vh"

module testbench;
	reg         clock = 1'b0;
	reg         resetn = 1'b0;
	reg  [7:0]  reg_addr = 8'h00;
	reg  [7:0]  reg_wdata = 8'h00;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg  [3:0]  ref_half = 4'h3;
	reg  [3:0]  lo_half = 4'h2;
	wire        ref_in, lo_in, ref_off_ff, bias_off_ff, lo_synth_off_ff, front_end_off_ff, adc_off_ff;
	wire        front_end_bias_pin_a_oe_n_ff, front_end_bias_pin_b_oe_n_ff, filter_clk_en_ff, clk_buffer_off_ff;
	wire        master_ref_standby_ff, local_osc_pump_output_oe_n_ff, ref_div_pulse_ff, fb_div_pulse_ff;
	wire        local_osc_pump_output_up_ff, local_osc_pump_output_down_ff;
	wire [7:0]  reg_rdata_ff;
	wire [3:0]  pump_current_mult_ff;
	wire [10:0] sb_vec = {ref_off_ff, bias_off_ff, lo_synth_off_ff, front_end_off_ff, front_end_bias_pin_a_oe_n_ff,
		front_end_bias_pin_b_oe_n_ff, adc_off_ff, filter_clk_en_ff, clk_buffer_off_ff, master_ref_standby_ff,
		local_osc_pump_output_oe_n_ff};
	// address, readable mask and reset value per register; 0x05 is unmapped
	localparam [71:0] ADR = 72'h00_08_09_0a_0b_0c_0d_0e_05;
	localparam [71:0] MSK = 72'hff_3f_ff_ff_ff_7f_3f_ff_ff;
	localparam [71:0] RST = 72'hff_00_38_a0_1d_00_00_04_00;
	integer     errors = 0;
	integer     checked = 0;
	integer     i, rcnt, lcnt, rskip, lskip, exp_r, exp_n;
	integer     ups = 0;
	integer     dns = 0;
	reg  [31:0] seed = 32'he398;
	reg  [7:0]  v, a, m;
	reg  [15:0] q;
	reg  [15:0] rd_q[$];
	reg  [10:0] dec_q[$];
	reg  [1:0]  rsh = 2'b00;
	reg  [2:0]  dsh = 3'b000;
	reg         div_on = 1'b0;
	reg         rp = 1'b0;
	reg         lp = 1'b0;

	always #4 clock = ~clock;

	lsd_src lsd_src_inst (.clock, .resetn, .ref_half, .lo_half, .ref_in, .lo_in);
	lsd_ctrl lsd_ctrl_inst (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .ref_in, .lo_in,
		.ref_off_ff, .bias_off_ff, .lo_synth_off_ff, .front_end_off_ff, .front_end_bias_pin_a_oe_n_ff,
		.front_end_bias_pin_b_oe_n_ff, .adc_off_ff, .filter_clk_en_ff, .clk_buffer_off_ff, .master_ref_standby_ff,
		.local_osc_pump_output_up_ff, .local_osc_pump_output_down_ff, .local_osc_pump_output_oe_n_ff,
		.pump_current_mult_ff, .ref_div_pulse_ff, .fb_div_pulse_ff);

	// --------------------------------------------------
	// helpers
	// --------------------------------------------------
	function [10:0] dec(input [7:0] s);
		dec = {s[7], s[7], s[6], s[2], s[2], s[2], s[0], ~s[0], s[0] & s[4], (s & 8'hfd) == 8'hfd, s[6]};
	endfunction

	task cmp(input string nm, input [15:0] e, input [15:0] s);
		begin
			checked = checked + 1;
			if (s !== e) begin
				errors = errors + 1;
				$display("FAIL %s expected %h seen %h", nm, e, s);
			end
		end
	endtask

	// only this one device is addressed on the port
	task wr(input [7:0] ad, input [7:0] d);
		begin
			@(negedge clock);
			reg_addr = ad;
			reg_wdata = d;
			reg_wr = 1'b1;
			if (ad == `LSD_ADDR_STANDBY)
				dec_q.push_back(dec(d));
			@(negedge clock);
			reg_wr = 1'b0;
		end
	endtask

	task rd(input [7:0] ad, input [7:0] mk, input [7:0] e);
		begin
			@(negedge clock);
			reg_addr = ad;
			reg_rd = 1'b1;
			rd_q.push_back({mk, e & mk});
			@(negedge clock);
			reg_rd = 1'b0;
		end
	endtask

	task results;
		begin
			$display("checked %0d errors %0d", checked, errors);
			if (errors == 0 && checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask

	// --------------------------------------------------
	// monitor: takes the oldest note whenever a result shows
	// --------------------------------------------------
	always @(posedge clock) begin
		if (rsh[1]) begin
			q = rd_q.pop_front();
			cmp("rdata", {8'h00, q[7:0]}, {8'h00, reg_rdata_ff & q[15:8]});
		end
		if (dsh[2])
			cmp("standby outputs", {5'h00, dec_q.pop_front()}, {5'h00, sb_vec});
		rsh <= {rsh[0], reg_rd};
		dsh <= {dsh[1:0], reg_wr && reg_addr == `LSD_ADDR_STANDBY};
		if (div_on && ref_div_pulse_ff) begin
			if (rskip > 0)
				rskip = rskip - 1;
			else
				cmp("ref edges", exp_r, rcnt);
			rcnt = 0;
		end
		if (div_on && fb_div_pulse_ff) begin
			if (lskip > 0)
				lskip = lskip - 1;
			else
				cmp("lo edges", exp_n, lcnt);
			lcnt = 0;
		end
		// pump direction is only counted once the feedback divider has settled
		if (div_on && lskip == 0 && local_osc_pump_output_up_ff)
			ups = ups + 1;
		if (div_on && lskip == 0 && local_osc_pump_output_down_ff)
			dns = dns + 1;
		if (ref_in && !rp)
			rcnt = rcnt + 1;
		if (lo_in && !lp)
			lcnt = lcnt + 1;
		rp = ref_in;
		lp = lo_in;
	end

	initial begin
		#160000;
		errors = errors + 1;
		results;
	end

	// --------------------------------------------------
	// main sequence
	// --------------------------------------------------
	initial begin
		repeat (4) @(posedge clock);
		@(negedge clock) resetn = 1'b1;
		cmp("reset outputs", {5'h00, dec(8'hff)}, {5'h00, sb_vec});
		for (i = 0; i < 9; i = i + 1)
			rd(ADR[8*i +: 8], MSK[8*i +: 8], RST[8*i +: 8]);
		for (i = 0; i < 9; i = i + 1) begin
			a = ADR[8*i +: 8];
			m = MSK[8*i +: 8];
			v = $random(seed);
			// main count stays at least 3 and above the swallow count
			if (a == 8'h0b)
				v[7] = 1'b1;
			if (a == 8'h0a)
				v[0] = 1'b1;
			wr(a, v);
			rd(a, m, (a == 8'h05) ? 8'h00 : v);
		end
		for (i = 0; i < 8; i = i + 1)
			wr(`LSD_ADDR_STANDBY, ~(8'h01 << i));
		wr(`LSD_ADDR_STANDBY, 8'hff);
		wr(8'h0c, 8'h00);
		wr(`LSD_ADDR_STANDBY, 8'hbf);
		// main count above swallow count and at least 3
		for (i = 0; i < 2; i = i + 1) begin
			div_on = 1'b0;
			exp_r = i ? 5 : 1;
			v = i ? 8'd9 : 8'd3;
			m = i ? 8'd7 : 8'd2;
			wr(8'h08, 8'h00);
			wr(8'h09, exp_r[7:0]);
			// low main byte first so main count never drops to the swallow count
			wr(8'h0b, v);
			wr(8'h0a, {m[2:0], 5'h00});
			exp_n = 8 * v + m;
			rcnt = 0;
			lcnt = 0;
			rskip = 2;
			lskip = 2;
			div_on = 1'b1;
			repeat (exp_n * 20) @(negedge clock);
		end
		// reference runs faster than the divided lo, so the pump only sources
		cmp("pump up only", 16'h1, {15'h0, ups > 0 && dns == 0});
		wr(8'h0c, 8'h20);
		repeat (2) @(negedge clock);
		ups = 0;
		dns = 0;
		repeat (400) @(negedge clock);
		cmp("pump inverted", 16'h1, {15'h0, dns > 0 && ups == 0});
		for (i = 0; i < 8; i = i + 1) begin
			wr(8'h0c, {i[5:0], 2'b00});
			repeat (4) @(negedge clock);
			rd(8'h10, 8'hf0, {i[3:0] + 4'h1, 4'h0});
		end
		wr(8'h0c, 8'h40);
		repeat (600) @(negedge clock);
		cmp("fast mult", 16'h1, {15'h0, pump_current_mult_ff >= 4'h2});
		div_on = 1'b0;
		resetn = 1'b0;
		repeat (4) @(negedge clock);
		resetn = 1'b1;
		rd(`LSD_ADDR_STANDBY, 8'hff, 8'hff);
		repeat (4) @(negedge clock);
		results;
	end
endmodule
